/* File: lsbd_consts.vh */
// Purpose: constants for the logic/string/branch opcode decoder
// Assumes: byte-wide opcode stream from the prefetch queue
// Notes: opcode patterns are given as value and care mask, jump and return opcodes as exact byte values
`ifndef LSBD_CONSTS_VH
`define LSBD_CONSTS_VH

// ----------------------------------------------------------------------
// first-byte patterns (value, mask; jump and return opcodes as exact values)
// ----------------------------------------------------------------------
`define LSBD_SHROT_VAL 8'hD0
`define LSBD_SHROT_MSK 8'hFC
`define LSBD_TESTRM_VAL 8'h84
`define LSBD_TESTRM_MSK 8'hFE
`define LSBD_GRP3_VAL 8'hF6
`define LSBD_GRP3_MSK 8'hFE
`define LSBD_TESTAC_VAL 8'hA8
`define LSBD_TESTAC_MSK 8'hFE
`define LSBD_ORRM_VAL 8'h08
`define LSBD_XORRM_VAL 8'h30
`define LSBD_DW_MSK 8'hFC
`define LSBD_SMOV_VAL 8'hA4
`define LSBD_SCMP_VAL 8'hA6
`define LSBD_SSCN_VAL 8'hAE
`define LSBD_SLOD_VAL 8'hAC
`define LSBD_SSTO_VAL 8'hAA
`define LSBD_W_MSK 8'hFE
`define LSBD_REP_VAL 8'hF2
`define LSBD_JMP_NEAR 8'hE9
`define LSBD_JMP_FAR 8'hEA
`define LSBD_GRP5 8'hFF
`define LSBD_RET_NEAR 8'hC3
`define LSBD_RET_NEAR_IMM 8'hC2
`define LSBD_RET_FAR 8'hCB
`define LSBD_RET_FAR_IMM 8'hCA

// ----------------------------------------------------------------------
// extension field codes and field positions
// ----------------------------------------------------------------------
`define LSBD_EXT_RCR 3'h3
`define LSBD_EXT_TEST 3'h0
`define LSBD_EXT_JNEAR 3'h4
`define LSBD_EXT_JFAR 3'h5
`define LSBD_MOD_REG 2'h3
`define LSBD_MOD_NODISP 2'h0
`define LSBD_MOD_DISP8 2'h1
`define LSBD_RM_DIRECT 3'h6
`define LSBD_W_BIT 0
`define LSBD_D_BIT 1
`define LSBD_V_BIT 1
`define LSBD_Z_BIT 0

// ----------------------------------------------------------------------
// operation class codes
// ----------------------------------------------------------------------
`define LSBD_OP_NONE 5'h00
`define LSBD_OP_RCR 5'h01
`define LSBD_OP_TEST_RM 5'h02
`define LSBD_OP_TEST_IMM 5'h03
`define LSBD_OP_TEST_ACC 5'h04
`define LSBD_OP_OR_RM 5'h05
`define LSBD_OP_XOR_RM 5'h06
`define LSBD_OP_SMOVE 5'h07
`define LSBD_OP_SCMP 5'h08
`define LSBD_OP_SSCAN 5'h09
`define LSBD_OP_SLOAD 5'h0A
`define LSBD_OP_SSTORE 5'h0B
`define LSBD_OP_JMP_NEAR 5'h0C
`define LSBD_OP_JMP_FAR 5'h0D
`define LSBD_OP_JMP_IND 5'h0E
`define LSBD_OP_JMP_IND_FAR 5'h0F
`define LSBD_OP_RET_NEAR 5'h10
`define LSBD_OP_RET_NEAR_IMM 5'h11
`define LSBD_OP_RET_FAR 5'h12
`define LSBD_OP_RET_FAR_IMM 5'h13
`define LSBD_OP_ILLEGAL 5'h1F

`endif

/* File: lsbd_decoder.v */
// Purpose: opcode decoder for logic, string and branch instructions
// Assumes: one byte per cycle when byte_vld_i is high, same clock domain
// Notes: trailing bytes are gathered and the whole instruction is issued
//
// What this block does
// - shift group with extension 011 decodes as rotate_carry_right, v and w used
// - register TEST form: AND that only updates flags, no writeback
// - group-3 with extension 000 is TEST immediate; one or two data bytes
// - accumulator TEST immediate: data byte follows, second one if word
// - OR and XOR register forms take a modifier byte; d picks direction
// - string_move is one byte, w picks byte or word
// - string_compare is one byte, w picks byte or word
// - string_scan is one byte, w picks byte or word
// - string_load is one byte loading accumulator, w sized
// - string_store is one byte storing accumulator, w sized
// - jump forms: near disp16, far offset+segment, indirect via extension 100/101
// - near subroutine_exit is a lone opcode byte
// - near subroutine_exit with 16-bit immediate added to stack_pointer
// - far subroutine_exit, plain and with stack_pointer adjustment immediate
// - iterate_prefix: repeat bit compared with zero_flag for compare primitives
// - size bit set means word, cleared means byte
// - address form 11 means operand field selects a register
`timescale 1ns/1ps
`include "lsbd_consts.vh"

module lsbd_decoder (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // byte stream from prefetch queue
  input wire byte_vld_i,
  input wire [7:0] byte_i,
  output reg byte_rdy_o,
  // flags from execution unit
  input wire zero_flag_i,
  input wire iter_active_i,
  // decoded instruction to execution unit
  output reg instr_vld_o,
  output reg [4:0] op_class_o,
  output reg word_op_o,
  output reg to_reg_o,
  output reg count_cl_o,
  output reg flags_only_o,
  output reg sp_adjust_o,
  output reg rm_is_reg_o,
  output reg [1:0] mod_o,
  output reg [2:0] reg_o,
  output reg [2:0] rm_o,
  output reg [15:0] disp_o,
  output reg [15:0] imm_o,
  output reg [15:0] seg_o,
  output reg [2:0] length_o,
  output reg iter_prefix_o,
  output reg iter_cond_o,
  output reg iter_continue_o
);

  // ----------------------------------------------------------------------
  // states, one-hot
  // ----------------------------------------------------------------------
  localparam [3:0] S_OPC = 4'h1;
  localparam [3:0] S_MODRM = 4'h2;
  localparam [3:0] S_TAIL = 4'h4;
  localparam [3:0] S_ISSUE = 4'h8;

  function match;
    input [7:0] b;
    input [7:0] val;
    input [7:0] msk;
    begin
      match = ((b & msk) == val);
    end
  endfunction

  // displacement bytes implied by an addressing byte
  function [1:0] disp_len;
    input [7:0] m;
    begin
      if (m[7:6] == `LSBD_MOD_REG) begin
        disp_len = 2'd0;
      end else if (m[7:6] == `LSBD_MOD_DISP8) begin
        disp_len = 2'd1;
      end else if (m[7:6] == `LSBD_MOD_NODISP && m[2:0] != `LSBD_RM_DIRECT) begin
        disp_len = 2'd0;
      end else begin
        disp_len = 2'd2;
      end
    end
  endfunction

  reg [3:0] state_ff;
  reg [7:0] opc_ff;
  reg [7:0] mrm_ff;
  reg [1:0] ndisp_ff;
  reg [1:0] nimm_ff;
  reg nseg_ff;
  reg [1:0] idx_ff;
  reg rep_pend_ff;
  reg rep_z_ff;
  reg [4:0] cls_ff;

  wire take = byte_vld_i && byte_rdy_o;
  wire w_bit = opc_ff[`LSBD_W_BIT];
  wire [2:0] ext = byte_i[5:3];

  // ----------------------------------------------------------------------
  // first-byte classification
  // ----------------------------------------------------------------------
  reg [4:0] cls_c;
  reg need_mrm_c;
  reg [1:0] imm_c;
  reg seg_c;
  always @* begin
    cls_c = `LSBD_OP_ILLEGAL;
    need_mrm_c = 1'b0;
    imm_c = 2'd0;
    seg_c = 1'b0;
    if (match(byte_i, `LSBD_SHROT_VAL, `LSBD_SHROT_MSK)) begin
      cls_c = `LSBD_OP_RCR;
      need_mrm_c = 1'b1;
    end else if (match(byte_i, `LSBD_TESTRM_VAL, `LSBD_TESTRM_MSK)) begin
      cls_c = `LSBD_OP_TEST_RM;
      need_mrm_c = 1'b1;
    end else if (match(byte_i, `LSBD_GRP3_VAL, `LSBD_GRP3_MSK)) begin
      cls_c = `LSBD_OP_TEST_IMM;
      need_mrm_c = 1'b1;
    end else if (match(byte_i, `LSBD_TESTAC_VAL, `LSBD_TESTAC_MSK)) begin
      cls_c = `LSBD_OP_TEST_ACC;
      imm_c = byte_i[`LSBD_W_BIT] ? 2'd2 : 2'd1;
    end else if (match(byte_i, `LSBD_ORRM_VAL, `LSBD_DW_MSK)) begin
      cls_c = `LSBD_OP_OR_RM;
      need_mrm_c = 1'b1;
    end else if (match(byte_i, `LSBD_XORRM_VAL, `LSBD_DW_MSK)) begin
      cls_c = `LSBD_OP_XOR_RM;
      need_mrm_c = 1'b1;
    end else if (match(byte_i, `LSBD_SMOV_VAL, `LSBD_W_MSK)) begin
      cls_c = `LSBD_OP_SMOVE;
    end else if (match(byte_i, `LSBD_SCMP_VAL, `LSBD_W_MSK)) begin
      cls_c = `LSBD_OP_SCMP;
    end else if (match(byte_i, `LSBD_SSCN_VAL, `LSBD_W_MSK)) begin
      cls_c = `LSBD_OP_SSCAN;
    end else if (match(byte_i, `LSBD_SLOD_VAL, `LSBD_W_MSK)) begin
      cls_c = `LSBD_OP_SLOAD;
    end else if (match(byte_i, `LSBD_SSTO_VAL, `LSBD_W_MSK)) begin
      cls_c = `LSBD_OP_SSTORE;
    end else if (byte_i == `LSBD_JMP_NEAR) begin
      cls_c = `LSBD_OP_JMP_NEAR;
      imm_c = 2'd2;
    end else if (byte_i == `LSBD_JMP_FAR) begin
      cls_c = `LSBD_OP_JMP_FAR;
      imm_c = 2'd2;
      seg_c = 1'b1;
    end else if (byte_i == `LSBD_GRP5) begin
      cls_c = `LSBD_OP_JMP_IND;
      need_mrm_c = 1'b1;
    end else if (byte_i == `LSBD_RET_NEAR) begin
      cls_c = `LSBD_OP_RET_NEAR;
    end else if (byte_i == `LSBD_RET_NEAR_IMM) begin
      cls_c = `LSBD_OP_RET_NEAR_IMM;
      imm_c = 2'd2;
    end else if (byte_i == `LSBD_RET_FAR) begin
      cls_c = `LSBD_OP_RET_FAR;
    end else if (byte_i == `LSBD_RET_FAR_IMM) begin
      cls_c = `LSBD_OP_RET_FAR_IMM;
      imm_c = 2'd2;
    end
  end

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= S_OPC;
      opc_ff <= 8'h00;
      mrm_ff <= 8'h00;
      ndisp_ff <= 2'd0;
      nimm_ff <= 2'd0;
      nseg_ff <= 1'b0;
      idx_ff <= 2'd0;
      rep_pend_ff <= 1'b0;
      rep_z_ff <= 1'b0;
      cls_ff <= `LSBD_OP_NONE;
      byte_rdy_o <= 1'b0;
      instr_vld_o <= 1'b0;
      op_class_o <= `LSBD_OP_NONE;
      word_op_o <= 1'b0;
      to_reg_o <= 1'b0;
      count_cl_o <= 1'b0;
      flags_only_o <= 1'b0;
      sp_adjust_o <= 1'b0;
      rm_is_reg_o <= 1'b0;
      mod_o <= 2'h0;
      reg_o <= 3'h0;
      rm_o <= 3'h0;
      disp_o <= 16'h0000;
      imm_o <= 16'h0000;
      seg_o <= 16'h0000;
      length_o <= 3'd0;
      iter_prefix_o <= 1'b0;
      iter_cond_o <= 1'b0;
      iter_continue_o <= 1'b0;
    end else begin
      instr_vld_o <= 1'b0;
      byte_rdy_o <= (state_ff != S_ISSUE);
      // for string_compare and string_scan, repetition continues only while zero_flag equals the repeat bit; other classes pass iter_active_i through
      iter_continue_o <= iter_active_i && (op_class_o == `LSBD_OP_SCMP ||
        op_class_o == `LSBD_OP_SSCAN) ? (zero_flag_i == iter_cond_o) : iter_active_i;
      case (state_ff)
        S_OPC: begin
          if (take) begin
            length_o <= length_o + 3'd1;
            if (match(byte_i, `LSBD_REP_VAL, `LSBD_W_MSK)) begin
              rep_pend_ff <= 1'b1;
              rep_z_ff <= byte_i[`LSBD_Z_BIT];
            end else begin
              opc_ff <= byte_i;
              cls_ff <= cls_c;
              // near jump operand is a displacement, so it lands on disp_o
              nimm_ff <= (cls_c == `LSBD_OP_JMP_NEAR) ? 2'd0 : imm_c;
              nseg_ff <= seg_c;
              ndisp_ff <= (cls_c == `LSBD_OP_JMP_NEAR) ? 2'd2 : 2'd0;
              idx_ff <= 2'd0;
              disp_o <= 16'h0000;
              imm_o <= 16'h0000;
              seg_o <= 16'h0000;
              if (need_mrm_c) begin
                state_ff <= S_MODRM;
              end else if (imm_c != 2'd0) begin
                state_ff <= S_TAIL;
              end else begin
                state_ff <= S_ISSUE;
                byte_rdy_o <= 1'b0;
              end
            end
          end
        end
        S_MODRM: begin
          if (take) begin
            length_o <= length_o + 3'd1;
            mrm_ff <= byte_i;
            ndisp_ff <= disp_len(byte_i);
            if (cls_ff == `LSBD_OP_RCR && ext != `LSBD_EXT_RCR) begin
              cls_ff <= `LSBD_OP_ILLEGAL;
            end
            if (cls_ff == `LSBD_OP_TEST_IMM) begin
              if (ext == `LSBD_EXT_TEST) begin
                nimm_ff <= w_bit ? 2'd2 : 2'd1;
              end else begin
                cls_ff <= `LSBD_OP_ILLEGAL;
              end
            end
            if (cls_ff == `LSBD_OP_JMP_IND) begin
              if (ext == `LSBD_EXT_JFAR) begin
                cls_ff <= `LSBD_OP_JMP_IND_FAR;
              end else if (ext != `LSBD_EXT_JNEAR) begin
                cls_ff <= `LSBD_OP_ILLEGAL;
              end
            end
            if (disp_len(byte_i) != 2'd0 || (nimm_ff != 2'd0) ||
                (cls_ff == `LSBD_OP_TEST_IMM && ext == `LSBD_EXT_TEST)) begin
              state_ff <= S_TAIL;
            end else begin
              state_ff <= S_ISSUE;
              byte_rdy_o <= 1'b0;
            end
          end
        end
        S_TAIL: begin
          if (take) begin
            length_o <= length_o + 3'd1;
            idx_ff <= idx_ff + 2'd1;
            // displacement first, then immediate/offset, then segment, low byte first
            if (ndisp_ff != 2'd0) begin
              if (idx_ff == 2'd0) begin
                disp_o <= {{8{byte_i[7]}}, byte_i};
              end else begin
                disp_o[15:8] <= byte_i;
              end
              if (ndisp_ff == 2'd1 || idx_ff == 2'd1) begin
                ndisp_ff <= 2'd0;
                idx_ff <= 2'd0;
              end
            end else if (nimm_ff != 2'd0) begin
              if (idx_ff == 2'd0) begin
                imm_o[7:0] <= byte_i;
              end else begin
                imm_o[15:8] <= byte_i;
              end
              if (nimm_ff == 2'd1 || idx_ff == 2'd1) begin
                nimm_ff <= 2'd0;
                idx_ff <= 2'd0;
              end
            end else begin
              if (idx_ff == 2'd0) begin
                seg_o[7:0] <= byte_i;
              end else begin
                seg_o[15:8] <= byte_i;
                nseg_ff <= 1'b0;
              end
            end
            if ((ndisp_ff == 2'd0 && nseg_ff == 1'b0 && (nimm_ff == 2'd1 ||
                 (nimm_ff == 2'd2 && idx_ff == 2'd1))) ||
                (ndisp_ff == 2'd0 && nimm_ff == 2'd0 && idx_ff == 2'd1) ||
                (nimm_ff == 2'd0 && nseg_ff == 1'b0 && (ndisp_ff == 2'd1 ||
                 (ndisp_ff == 2'd2 && idx_ff == 2'd1)))) begin
              state_ff <= S_ISSUE;
              byte_rdy_o <= 1'b0;
            end
          end
        end
        S_ISSUE: begin
          instr_vld_o <= 1'b1;
          op_class_o <= cls_ff;
          word_op_o <= w_bit;
          to_reg_o <= opc_ff[`LSBD_D_BIT];
          count_cl_o <= (cls_ff == `LSBD_OP_RCR) && opc_ff[`LSBD_V_BIT];
          flags_only_o <= (cls_ff == `LSBD_OP_TEST_RM) || (cls_ff == `LSBD_OP_TEST_IMM) ||
            (cls_ff == `LSBD_OP_TEST_ACC);
          sp_adjust_o <= (cls_ff == `LSBD_OP_RET_NEAR_IMM) ||
            (cls_ff == `LSBD_OP_RET_FAR_IMM);
          rm_is_reg_o <= (mrm_ff[7:6] == `LSBD_MOD_REG);
          mod_o <= mrm_ff[7:6];
          reg_o <= mrm_ff[5:3];
          rm_o <= mrm_ff[2:0];
          iter_prefix_o <= rep_pend_ff;
          iter_cond_o <= rep_z_ff;
          rep_pend_ff <= 1'b0;
          mrm_ff <= 8'h00;
          state_ff <= S_OPC;
          byte_rdy_o <= 1'b1;
        end
        default: begin
          state_ff <= S_OPC;
        end
      endcase
      if (state_ff == S_ISSUE) begin
        length_o <= length_o;
      end else if (state_ff == S_OPC && instr_vld_o) begin
        length_o <= take ? 3'd1 : 3'd0;
      end
    end
  end

endmodule // lsbd_decoder

/* File: lsbd_decoder_checker.sv */
// Purpose: port-level checks on the logic/string/branch opcode decoder
// Assumes: single clock, asynchronous active-high reset
// Notes: only the top module's ports are watched
`timescale 1ns/1ps
`include "lsbd_consts.vh"
module lsbd_decoder_checker (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // stream and flags
  input wire byte_vld_i,
  input wire byte_rdy_o,
  input wire zero_flag_i,
  input wire iter_active_i,
  // decoded instruction
  input wire instr_vld_o,
  input wire [4:0] op_class_o,
  input wire flags_only_o,
  input wire sp_adjust_o,
  input wire rm_is_reg_o,
  input wire [1:0] mod_o,
  input wire [2:0] length_o,
  input wire iter_prefix_o,
  input wire iter_cond_o,
  input wire iter_continue_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  wire is_test = op_class_o == `LSBD_OP_TEST_RM || op_class_o == `LSBD_OP_TEST_IMM ||
    op_class_o == `LSBD_OP_TEST_ACC;
  wire is_adj = op_class_o == `LSBD_OP_RET_NEAR_IMM || op_class_o == `LSBD_OP_RET_FAR_IMM;
  wire is_cmp = op_class_o == `LSBD_OP_SCMP || op_class_o == `LSBD_OP_SSCAN;
  a_issue_pulse: assert property (instr_vld_o |=> !instr_vld_o)
    else $error("issue strobe wider than one cycle");
  a_refuse_issue: assert property (instr_vld_o |-> !$past(byte_rdy_o))
    else $error("byte accepted in issue state");
  a_answer_delay: assert property (instr_vld_o |-> $past(byte_vld_i && byte_rdy_o, 2))
    else $error("issue not two cycles after last byte");
  a_length_range: assert property (instr_vld_o |-> length_o >= 3'h1 && length_o <= 3'h6)
    else $error("length out of range");
  a_reg_form: assert property (instr_vld_o |-> rm_is_reg_o == (mod_o == 2'h3))
    else $error("register form flag wrong");
  a_flags_only: assert property (instr_vld_o |-> flags_only_o == is_test)
    else $error("flags-only flag wrong");
  a_stack_adjust: assert property (instr_vld_o |-> sp_adjust_o == is_adj)
    else $error("stack adjust flag wrong");
  a_fields_hold: assert property ($changed(op_class_o) |-> instr_vld_o)
    else $error("class changed between issues");
  a_iter_cond: assert property (iter_prefix_o && is_cmp |=> iter_continue_o ==
    ($past(iter_active_i) && ($past(iter_cond_o) == $past(zero_flag_i))))
    else $error("repeat continuation wrong");
  a_iter_follow: assert property (!is_cmp |=> iter_continue_o == $past(iter_active_i))
    else $error("repeat pass-through wrong");
endmodule // lsbd_decoder_checker
bind lsbd_decoder lsbd_decoder_checker chk (.mclk_i, .rst_i, .byte_vld_i, .byte_rdy_o,
  .zero_flag_i, .iter_active_i, .instr_vld_o, .op_class_o, .flags_only_o, .sp_adjust_o,
  .rm_is_reg_o,
  .mod_o, .length_o, .iter_prefix_o, .iter_cond_o, .iter_continue_o);

/* File: lsbd_decoder_tb.sv */
// Purpose: self-checking bench for the opcode decoder
// Assumes: prefetch model supplies bytes with random stalls
// Notes: expected results are queued per instruction, compared at issue
`timescale 1ns/1ps
`include "lsbd_consts.vh"
module lsbd_decoder_tb;
  typedef struct {logic [4:0] op; logic [2:0] len; logic [1:0] w; logic [1:0] sel;
    logic [15:0] v; logic [15:0] hd;} lsbd_note_t;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic zero_flag_i = 1'b1;
  logic iter_active_i = 1'b0;
  logic stall = 1'b0;
  logic byte_vld_i, byte_rdy_o, instr_vld_o, word_op_o;
  logic to_reg_o, count_cl_o, iter_prefix_o, iter_cond_o;
  logic [2:0] reg_o, rm_o;
  logic [7:0] byte_i;
  logic [4:0] op_class_o;
  logic [2:0] length_o;
  logic [15:0] disp_o, imm_o, seg_o;
  logic [31:0] seed = 32'hC7019DC7;
  lsbd_note_t notes[$];
  lsbd_note_t n;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  always #25 mclk_i = ~mclk_i;
  lsbd_prefetch_model pf (.mclk_i(mclk_i), .rst_i(rst_i), .stall_i(stall),
    .byte_rdy_i(byte_rdy_o), .byte_vld_o(byte_vld_i), .byte_o(byte_i));
  lsbd_decoder dut (.mclk_i(mclk_i), .rst_i(rst_i), .byte_vld_i(byte_vld_i), .byte_i(byte_i),
    .byte_rdy_o(byte_rdy_o), .zero_flag_i(zero_flag_i), .iter_active_i(iter_active_i),
    .instr_vld_o(instr_vld_o), .op_class_o(op_class_o), .word_op_o(word_op_o),
    .to_reg_o(to_reg_o), .count_cl_o(count_cl_o), .flags_only_o(), .sp_adjust_o(),
    .rm_is_reg_o(), .mod_o(), .reg_o(reg_o), .rm_o(rm_o), .disp_o(disp_o), .imm_o(imm_o),
    .seg_o(seg_o), .length_o(length_o), .iter_prefix_o(iter_prefix_o),
    .iter_cond_o(iter_cond_o), .iter_continue_o());
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // first byte in bits 7:0, stream order upward
  task automatic put(input logic [39:0] b, input int k, input logic [4:0] op,
    input logic [1:0] w, input logic [1:0] sel, input logic [15:0] v);
    notes.push_back('{op, k[2:0], w, sel, v, b[15:0]});
    for (int i = 0; i < k; i++) pf.push(b[i*8 +: 8]);
  endtask
  // ----------------------------------------------------------------------
  // checking side
  // ----------------------------------------------------------------------
  always @(posedge mclk_i) begin
    cycles++;
    if (!rst_i && instr_vld_o === 1'b1) begin
      n = notes.pop_front();
      chk({11'h0, op_class_o}, {11'h0, n.op});
      chk({13'h0, length_o}, {13'h0, n.len});
      if (n.w != 2'h2) chk({15'h0, word_op_o}, {15'h0, n.w[0]});
      if (n.sel == 2'h1) chk(disp_o, n.v);
      if (n.sel == 2'h2) chk(imm_o, n.v);
      if (n.sel == 2'h3) chk(seg_o, n.v);
      if (n.op inside {`LSBD_OP_OR_RM, `LSBD_OP_XOR_RM})
        chk({15'h0, to_reg_o}, {15'h0, n.hd[1]});
      if (n.op == `LSBD_OP_RCR) chk({15'h0, count_cl_o}, {15'h0, n.hd[1]});
      if (n.op inside {`LSBD_OP_RCR, `LSBD_OP_TEST_RM, `LSBD_OP_TEST_IMM, `LSBD_OP_OR_RM,
          `LSBD_OP_XOR_RM, `LSBD_OP_JMP_IND, `LSBD_OP_JMP_IND_FAR})
        chk({10'h0, reg_o, rm_o}, {10'h0, n.hd[13:8]});
      chk({15'h0, iter_prefix_o}, {15'h0, n.hd[7:1] == 7'h79});
      if (n.hd[7:1] == 7'h79) chk({15'h0, iter_cond_o}, {15'h0, n.hd[0]});
    end
    if (cycles > 4000) begin
      fail_count++;
      conclude();
    end
  end
  always @(posedge mclk_i) begin
    #1;
    seed = xs(seed);
    stall = seed[0] & seed[1];
    zero_flag_i = seed[2];
    iter_active_i = seed[3];
  end
  // ----------------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------------
  task automatic load_all;
    put(40'hD8D3, 2, `LSBD_OP_RCR, 2'h1, 2'h0, 16'h0);
    put({24'h0, 2'b11, seed[5:0], 8'h84}, 2, `LSBD_OP_TEST_RM, 2'h0, 2'h0, 16'h0);
    put(40'h1234C0F7, 4, `LSBD_OP_TEST_IMM, 2'h1, 2'h2, 16'h1234);
    put(40'h5AC1F6, 3, `LSBD_OP_TEST_IMM, 2'h0, 2'h2, 16'h005A);
    put(40'hABCDA9, 3, `LSBD_OP_TEST_ACC, 2'h1, 2'h2, 16'hABCD);
    put(40'h11A8, 2, `LSBD_OP_TEST_ACC, 2'h0, 2'h2, 16'h0011);
    put(40'hC80B, 2, `LSBD_OP_OR_RM, 2'h1, 2'h0, 16'h0);
    put(40'hD130, 2, `LSBD_OP_XOR_RM, 2'h0, 2'h0, 16'h0);
    for (int w = 0; w < 2; w++) begin
      put({32'h0, 8'hA4 | w[7:0]}, 1, `LSBD_OP_SMOVE, w[1:0], 2'h0, 16'h0);
      put({32'h0, 8'hA6 | w[7:0]}, 1, `LSBD_OP_SCMP, w[1:0], 2'h0, 16'h0);
      put({32'h0, 8'hAE | w[7:0]}, 1, `LSBD_OP_SSCAN, w[1:0], 2'h0, 16'h0);
      put({32'h0, 8'hAC | w[7:0]}, 1, `LSBD_OP_SLOAD, w[1:0], 2'h0, 16'h0);
      put({32'h0, 8'hAA | w[7:0]}, 1, `LSBD_OP_SSTORE, w[1:0], 2'h0, 16'h0);
    end
    put(40'hA6F3, 2, `LSBD_OP_SCMP, 2'h0, 2'h0, 16'h0);
    put(40'hAFF2, 2, `LSBD_OP_SSCAN, 2'h1, 2'h0, 16'h0);
    put(40'h1234E9, 3, `LSBD_OP_JMP_NEAR, 2'h2, 2'h1, 16'h1234);
    put(40'h12345678EA, 5, `LSBD_OP_JMP_FAR, 2'h2, 2'h3, 16'h1234);
    put(40'hE0FF, 2, `LSBD_OP_JMP_IND, 2'h2, 2'h0, 16'h0);
    put(40'hE8FF, 2, `LSBD_OP_JMP_IND_FAR, 2'h2, 2'h0, 16'h0);
    put(40'hF8FF, 2, `LSBD_OP_ILLEGAL, 2'h2, 2'h0, 16'h0);
    put(40'hC3, 1, `LSBD_OP_RET_NEAR, 2'h2, 2'h0, 16'h0);
    put({16'h0, seed[23:8], 8'hC2}, 3, `LSBD_OP_RET_NEAR_IMM, 2'h2, 2'h2, seed[23:8]);
    put(40'hCB, 1, `LSBD_OP_RET_FAR, 2'h2, 2'h0, 16'h0);
    put(40'h0108CA, 3, `LSBD_OP_RET_FAR_IMM, 2'h2, 2'h2, 16'h0108);
  endtask
  task automatic drain(input string name);
    while (notes.size() > 0) @(posedge mclk_i);
    repeat (3) @(posedge mclk_i);
    $display("test %s done", name);
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #1 load_all();
    drain("table");
    #1 rst_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #1 load_all();
    drain("after_reset");
    conclude();
  end
endmodule // lsbd_decoder_tb

/* File: lsbd_prefetch_model.sv */
// Purpose: behavioural prefetch queue feeding the decoder
// Assumes: bytes pushed by the bench, one offered at a time
// Notes: an offered byte is held until taken; stall only delays new offers
`timescale 1ns/1ps
module lsbd_prefetch_model (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // control
  input wire stall_i,
  input wire byte_rdy_i,
  // stream
  output logic byte_vld_o,
  output logic [7:0] byte_o
);
  logic [7:0] q[$];
  logic tk;
  initial begin
    byte_vld_o = 1'b0;
    byte_o = 8'h00;
  end
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
  always @(posedge mclk_i) begin
    tk = byte_vld_o && byte_rdy_i;
    #1;
    if (rst_i) begin
      q.delete();
      byte_vld_o = 1'b0;
    end else if (tk) begin
      void'(q.pop_front());
      if (q.size() > 0 && !stall_i) begin
        byte_o = q[0];
      end else begin
        byte_vld_o = 1'b0;
        // idle line shows no stale byte
        byte_o = ~byte_o;
      end
    end else if (!byte_vld_o && q.size() > 0 && !stall_i) begin
      byte_vld_o = 1'b1;
      byte_o = q[0];
    end
  end
endmodule // lsbd_prefetch_model
